// >>> design/rmg_gateway.sv
// register mirror gateway between network requests and the inverter registers
// ----------------------------------------------------------------------------
// Summary of operation
// - continuously read or write every scanned register and mirror it locally
// - network access to scanned registers completes from mirror, no inverter request
// - scanned writes are not range checked and never answer with an error
// - every number in the scanned ranges succeeds and owns a mirror word
// - scanned class is the command group plus both monitor groups
// - configuration and alarm codes are non-scanned and not polled
// - non-scanned access is forwarded to the inverter before answering
// - inverter errors on non-scanned access go back to the client, except a missing register after the start
// - a single non-scanned register that does not exist gives an error
// - multi-read: start must exist, other missing registers read as zero
// - multi-read forwards only within its starting group; non-scanned registers past it read as zero
// - multi-write: start must exist, data for missing registers is dropped
// - multi-write forwards only within its starting group; data for non-scanned registers past it is dropped
// - register number is group times 256 plus offset plus one
// ----------------------------------------------------------------------------
`timescale 1ns/100ps

module rmg_gateway
  import rmg_pkg::*;
#(
  parameter int unsigned MIR_DEPTH = `RMG_MIR_DEPTH
)(
  // clock, reset, enable
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  // network request
  input  wire logic                   net_req_valid_i,
  output logic                        net_req_ready_o,
  input  wire rmg_net_req_s           net_req_i,
  // network write data, one word per register
  input  wire logic                   net_wd_valid_i,
  output logic                        net_wd_ready_o,
  input  wire logic [`RMG_DATA_W-1:0] net_wd_i,
  // network response, one beat per register
  output logic                        net_rsp_valid_o,
  input  wire logic                   net_rsp_ready_i,
  output rmg_net_rsp_s                net_rsp_o,
  // inverter request
  output logic                        inv_req_valid_o,
  input  wire logic                   inv_req_ready_i,
  output rmg_inv_req_s                inv_req_o,
  // inverter response
  input  wire logic                   inv_rsp_valid_i,
  input  wire rmg_inv_rsp_s           inv_rsp_i
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  rmg_state_e              state_q;
  logic                    write_q;
  logic [`RMG_REG_W-1:0]   addr_q;
  logic [`RMG_CNT_W-1:0]   left_q;
  logic [`RMG_CNT_W-1:0]   count_q;
  logic                    first_q;
  logic [`RMG_GRP_W-1:0]   grp0_q;
  logic [`RMG_DATA_W-1:0]  wd_q;
  logic                    inv_busy_q;
  logic                    owner_fwd_q;
  logic [`RMG_IDX_W-1:0]   scan_idx_q;
  logic [`RMG_IDX_W-1:0]   scan_pend_q;
  logic [`RMG_DATA_W-1:0]  mirror [MIR_DEPTH];

  logic                    cur_scanned;
  logic                    cur_cmd;
  logic [`RMG_IDX_W-1:0]   cur_idx;
  logic [`RMG_GRP_W-1:0]   cur_grp;
  logic                    last_beat;
  logic                    inv_issue;
  logic                    fwd_issue;
  logic                    inv_done;
  logic                    net_mir_we;
  logic                    scan_mir_we;
  logic                    rsp_fire;

  // --------------------------------------------------------------------------
  // classification of the register being served
  // --------------------------------------------------------------------------
  rmg_reg_map u_map (
    .regnum_i  (addr_q),
    .scanned_o (cur_scanned),
    .command_o (cur_cmd),
    .idx_o     (cur_idx),
    .grp_o     (cur_grp)
  );

  // mirror index back to a register number for the scanner
  function automatic logic [`RMG_REG_W-1:0] idx_to_reg(input logic [`RMG_IDX_W-1:0] idx);
    logic [`RMG_REG_W-1:0] wide;
    wide = {{(`RMG_REG_W-`RMG_IDX_W){1'b0}}, idx};
    if (idx < `RMG_M1_BASE) begin
      idx_to_reg = `RMG_S_FIRST + wide;
    end else if (idx < `RMG_M2_BASE) begin
      idx_to_reg = `RMG_M1_FIRST + wide - {8'h00, `RMG_M1_BASE};
    end else begin
      idx_to_reg = `RMG_M2_FIRST + wide - {8'h00, `RMG_M2_BASE};
    end
  endfunction : idx_to_reg

  // --------------------------------------------------------------------------
  // handshakes
  // --------------------------------------------------------------------------
  assign last_beat       = (left_q == `RMG_CNT_W'(1));
  assign net_req_ready_o = ce_i && (state_q == RMG_IDLE);
  assign net_wd_ready_o  = ce_i && (state_q == RMG_BEAT) && write_q;
  assign rsp_fire        = ce_i && net_rsp_valid_o && net_rsp_ready_i;
  // the port has one access in flight; forwarding outranks the scan
  assign inv_issue       = ce_i && !inv_busy_q;
  assign fwd_issue       = inv_issue && (state_q == RMG_FWD);
  assign inv_done        = ce_i && inv_busy_q && inv_rsp_valid_i && !inv_req_valid_o;
  // a scanned write lands in the mirror only, with no value check
  assign net_mir_we      = (state_q == RMG_BEAT) && write_q && cur_scanned
                           && net_wd_valid_i && ce_i;
  // a monitor read refreshes the mirror unless the network writes now
  assign scan_mir_we     = inv_done && !owner_fwd_q && !inv_rsp_i.err && !net_mir_we
                           && (scan_pend_q >= `RMG_M1_BASE);

  // --------------------------------------------------------------------------
  // mirror memory: one word for every scanned number, existing or not
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < MIR_DEPTH; i++) begin
        mirror[i] <= `RMG_MIR_RST;
      end
    end else if (net_mir_we) begin
      mirror[cur_idx] <= net_wd_i;
    end else if (scan_mir_we) begin
      mirror[scan_pend_q] <= inv_rsp_i.rdata;
    end
  end

  // --------------------------------------------------------------------------
  // inverter port: issue, ownership and completion
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inv_req_valid_o <= 1'b0;
      inv_req_o       <= '0;
      inv_busy_q      <= 1'b0;
      owner_fwd_q     <= 1'b0;
      scan_pend_q     <= '0;
    end else if (ce_i) begin
      if (inv_req_valid_o && inv_req_ready_i) begin
        inv_req_valid_o <= 1'b0;
      end
      if (inv_done) begin
        inv_busy_q <= 1'b0;
      end else if (fwd_issue) begin
        // non-scanned access goes to the inverter first
        inv_req_valid_o <= 1'b1;
        inv_busy_q      <= 1'b1;
        owner_fwd_q     <= 1'b1;
        inv_req_o       <= '{write: write_q, regnum: addr_q, wdata: wd_q};
      end else if (inv_issue) begin
        // commands are pushed out, monitors are pulled in
        inv_req_valid_o <= 1'b1;
        inv_busy_q      <= 1'b1;
        owner_fwd_q     <= 1'b0;
        scan_pend_q     <= scan_idx_q;
        inv_req_o       <= '{write:  (scan_idx_q < `RMG_M1_BASE),
                             regnum: idx_to_reg(scan_idx_q),
                             wdata:  mirror[scan_idx_q]};
      end
    end
  end

  // scan pointer sweeps the whole mirror without pause
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_idx_q <= '0;
    end else if (ce_i && inv_issue && !fwd_issue && !inv_done) begin
      scan_idx_q <= (scan_idx_q == `RMG_MIR_LAST) ? '0 : scan_idx_q + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // transaction sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q         <= RMG_IDLE;
      write_q         <= 1'b0;
      addr_q          <= '0;
      left_q          <= '0;
      count_q         <= '0;
      first_q         <= 1'b0;
      grp0_q          <= '0;
      wd_q            <= '0;
      net_rsp_valid_o <= 1'b0;
      net_rsp_o       <= '0;
    end else if (ce_i) begin
      unique case (state_q)
        RMG_IDLE: begin
          if (net_req_valid_i) begin
            write_q <= net_req_i.write;
            addr_q  <= net_req_i.start;
            left_q  <= net_req_i.count;
            count_q <= net_req_i.count;
            first_q <= 1'b1;
            state_q <= RMG_CHECK;
          end
        end
        RMG_CHECK: begin
          grp0_q <= cur_grp;            // starting group bounds the forwarded registers
          // oversize non-scanned requests never touch a register
          if ((count_q == '0) || (!cur_scanned && count_q > `RMG_MAX_NS)) begin
            net_rsp_o       <= '{data: `RMG_ZERO_DATA, err: 1'b1, last: 1'b1};
            net_rsp_valid_o <= 1'b1;
            state_q         <= RMG_RESP;
          end else begin
            state_q <= RMG_BEAT;
          end
        end
        RMG_BEAT: begin
          if (cur_scanned) begin
            // mirror answers at once and never fails
            if (!write_q || net_wd_valid_i) begin
              net_rsp_o       <= '{data: write_q ? `RMG_ZERO_DATA : mirror[cur_idx],
                                   err: 1'b0, last: last_beat};
              net_rsp_valid_o <= 1'b1;
              state_q         <= RMG_RESP;
            end
          end else if (cur_grp != grp0_q) begin
            // past the starting group: read zero, drop write data
            if (!write_q || net_wd_valid_i) begin
              net_rsp_o       <= '{data: `RMG_ZERO_DATA, err: 1'b0, last: last_beat};
              net_rsp_valid_o <= 1'b1;
              state_q         <= RMG_RESP;
            end
          end else if (!write_q || net_wd_valid_i) begin
            wd_q    <= net_wd_i;
            state_q <= RMG_FWD;
          end
        end
        RMG_FWD: begin
          if (fwd_issue) begin
            state_q <= RMG_WAIT;
          end
        end
        RMG_WAIT: begin
          if (inv_done && owner_fwd_q) begin
            net_rsp_valid_o <= 1'b1;
            state_q         <= RMG_RESP;
            if (inv_rsp_i.err && (first_q || !inv_rsp_i.noexist)) begin
              // starting register missing, or data refused
              net_rsp_o <= '{data: `RMG_ZERO_DATA, err: 1'b1, last: 1'b1};
            end else if (inv_rsp_i.err) begin
              // missing later register: zero on read, write ignored
              net_rsp_o <= '{data: `RMG_ZERO_DATA, err: 1'b0, last: last_beat};
            end else begin
              net_rsp_o <= '{data: write_q ? `RMG_ZERO_DATA : inv_rsp_i.rdata,
                             err: 1'b0, last: last_beat};
            end
          end
        end
        RMG_RESP: begin
          if (rsp_fire) begin
            net_rsp_valid_o <= 1'b0;
            if (net_rsp_o.last) begin
              state_q <= RMG_IDLE;
            end else begin
              addr_q  <= addr_q + 1'b1;
              left_q  <= left_q - 1'b1;
              first_q <= 1'b0;
              state_q <= RMG_BEAT;
            end
          end
        end
        default: begin
          state_q <= RMG_IDLE;          // codes 6 and 7 are illegal
        end
      endcase
    end
  end

endmodule : rmg_gateway

// >>> include/rmg_cfg.svh
// constants of the register mirror gateway
`ifndef RMG_CFG_SVH
`define RMG_CFG_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define RMG_REG_W      16
`define RMG_DATA_W     16
`define RMG_CNT_W      8
`define RMG_IDX_W      8
`define RMG_GRP_W      8

// ----------------------------------------------------------------------------
// register numbering: group * 256 + offset + 1
// ----------------------------------------------------------------------------
`define RMG_GRP_SHIFT  8
`define RMG_REG_BIAS   16'h0001

// ----------------------------------------------------------------------------
// scanned ranges (command, monitor 1, monitor 2) and mirror layout
// ----------------------------------------------------------------------------
`define RMG_S_FIRST    16'h0702
`define RMG_S_LAST     16'h070f
`define RMG_M1_FIRST   16'h0802
`define RMG_M1_LAST    16'h084a
`define RMG_M2_FIRST   16'h0f02
`define RMG_M2_LAST    16'h0f61
`define RMG_M1_BASE    8'h0e
`define RMG_M2_BASE    8'h57
`define RMG_MIR_DEPTH  183
`define RMG_MIR_LAST   8'hb6
`define RMG_MIR_RST    16'h0000

// ----------------------------------------------------------------------------
// transaction limits
// ----------------------------------------------------------------------------
`define RMG_MAX_NS     8'h32
`define RMG_ZERO_DATA  16'h0000

`endif

// >>> include/rmg_pkg.sv
// types shared by the register mirror gateway
`include "rmg_cfg.svh"

package rmg_pkg;

  // --------------------------------------------------------------------------
  // network side
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                   write;
    logic [`RMG_REG_W-1:0]  start;
    logic [`RMG_CNT_W-1:0]  count;
  } rmg_net_req_s;

  typedef struct packed {
    logic [`RMG_DATA_W-1:0] data;
    logic                   err;
    logic                   last;
  } rmg_net_rsp_s;

  // --------------------------------------------------------------------------
  // inverter side
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                   write;
    logic [`RMG_REG_W-1:0]  regnum;
    logic [`RMG_DATA_W-1:0] wdata;
  } rmg_inv_req_s;

  typedef struct packed {
    logic [`RMG_DATA_W-1:0] rdata;
    logic                   err;
    logic                   noexist;
  } rmg_inv_rsp_s;

  typedef enum logic [2:0] {
    RMG_IDLE  = 3'b000,
    RMG_CHECK = 3'b001,
    RMG_BEAT  = 3'b010,
    RMG_FWD   = 3'b011,
    RMG_WAIT  = 3'b100,
    RMG_RESP  = 3'b101
  } rmg_state_e;

endpackage : rmg_pkg

// >>> design/rmg_reg_map.sv
// classifies a register number and maps scanned ones onto the mirror
`timescale 1ns/100ps

module rmg_reg_map
  import rmg_pkg::*;
(
  // register number under test
  input  wire logic [`RMG_REG_W-1:0] regnum_i,
  // classification
  output logic                       scanned_o,
  output logic                       command_o,
  output logic [`RMG_IDX_W-1:0]      idx_o,
  output logic [`RMG_GRP_W-1:0]      grp_o
);

  logic [`RMG_REG_W-1:0] off_s;
  logic [`RMG_REG_W-1:0] off_m1;
  logic [`RMG_REG_W-1:0] off_m2;
  logic [`RMG_REG_W-1:0] biased;

  assign off_s  = regnum_i - `RMG_S_FIRST;
  assign off_m1 = regnum_i - `RMG_M1_FIRST;
  assign off_m2 = regnum_i - `RMG_M2_FIRST;
  // group number is recovered by undoing the plus-one bias
  assign biased = regnum_i - `RMG_REG_BIAS;
  assign grp_o  = biased[`RMG_REG_W-1:`RMG_GRP_SHIFT];

  // command and both monitor groups form the scanned class
  always_comb begin
    scanned_o = 1'b1;
    command_o = 1'b0;
    idx_o     = '0;
    if (regnum_i >= `RMG_S_FIRST && regnum_i <= `RMG_S_LAST) begin
      command_o = 1'b1;
      idx_o     = off_s[`RMG_IDX_W-1:0];
    end else if (regnum_i >= `RMG_M1_FIRST && regnum_i <= `RMG_M1_LAST) begin
      idx_o     = off_m1[`RMG_IDX_W-1:0] + `RMG_M1_BASE;
    end else if (regnum_i >= `RMG_M2_FIRST && regnum_i <= `RMG_M2_LAST) begin
      idx_o     = off_m2[`RMG_IDX_W-1:0] + `RMG_M2_BASE;
    end else begin
      scanned_o = 1'b0;                 // configuration and alarm groups
    end
  end

endmodule : rmg_reg_map

// >>> sim/rmg_gateway_sva.sv
// port checker of the register mirror gateway
`timescale 1ns/100ps
`include "rmg_cfg.svh"

module rmg_gateway_sva
  import rmg_pkg::*;
#(
  parameter int unsigned MIR_DEPTH = `RMG_MIR_DEPTH
)(
  // clock, reset, enable
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         ce_i,
  // network side
  input wire logic         net_req_valid_i,
  input wire logic         net_req_ready_o,
  input wire rmg_net_req_s net_req_i,
  input wire logic         net_rsp_valid_o,
  input wire logic         net_rsp_ready_i,
  input wire rmg_net_rsp_s net_rsp_o,
  // inverter side
  input wire logic         inv_req_valid_o,
  input wire logic         inv_req_ready_i,
  input wire rmg_inv_req_s inv_req_o,
  input wire logic         inv_rsp_valid_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------------
  function automatic logic scan_f(input logic [15:0] r);
    return (r >= `RMG_S_FIRST && r <= `RMG_S_LAST) || (r >= `RMG_M1_FIRST && r <= `RMG_M1_LAST)
      || (r >= `RMG_M2_FIRST && r <= `RMG_M2_LAST);
  endfunction : scan_f

  logic busy_q;  // an inverter access is in flight
  logic scan_q;  // legal scanned transaction open
  logic fwd_q;   // legal forwarded transaction open
  wire  take = net_req_valid_i && net_req_ready_o && ce_i;
  wire  fin  = net_rsp_valid_o && net_rsp_ready_i && net_rsp_o.last && ce_i;
  wire  ok   = net_req_i.count != 8'h00 &&
               (scan_f(net_req_i.start) || net_req_i.count <= `RMG_MAX_NS);
  wire  idle = !inv_req_valid_o && !busy_q;

  // track the inverter access in flight
  always_ff @(posedge clk_i) begin
    if (rst_i || inv_rsp_valid_i) busy_q <= 1'b0;
    else if (inv_req_valid_o && inv_req_ready_i) busy_q <= 1'b1;
  end

  // track the class of the open network transaction
  always_ff @(posedge clk_i) begin
    if (rst_i || fin) begin
      scan_q <= 1'b0;
      fwd_q  <= 1'b0;
    end else if (take) begin
      scan_q <= ok && scan_f(net_req_i.start);
      fwd_q  <= ok && !scan_f(net_req_i.start);
    end
  end

  sequence s_scan_read;
    take && !net_req_i.write && net_req_i.count != 8'h00 && scan_f(net_req_i.start);
  endsequence
  sequence s_first_beat;
    !net_rsp_valid_o ##[1:2] net_rsp_valid_o;
  endsequence
  sequence s_err_beat;
    net_rsp_valid_o && net_rsp_o.err && net_rsp_o.last;
  endsequence

  a_scan_fast: assert property (s_scan_read |=> s_first_beat)
    else $error("scanned read not answered at once");
  a_refuse_err: assert property (take && !ok |-> ##[1:4] s_err_beat)
    else $error("oversized or empty request not refused");
  a_scan_clean: assert property (net_rsp_valid_o && scan_q |-> !net_rsp_o.err)
    else $error("scanned access answered with an error");
  a_err_last: assert property (net_rsp_valid_o && net_rsp_o.err |-> net_rsp_o.last)
    else $error("error beat does not end the transaction");
  a_rsp_hold: assert property (net_rsp_valid_o && !net_rsp_ready_i
    |=> net_rsp_valid_o && $stable(net_rsp_o)) else $error("response beat changed early");
  a_inv_hold: assert property (inv_req_valid_o && !inv_req_ready_i
    |=> inv_req_valid_o && $stable(inv_req_o)) else $error("inverter request changed early");
  a_one_access: assert property (inv_req_valid_o |-> !busy_q)
    else $error("second inverter access while one is in flight");
  a_scan_fill: assert property (idle [*3] |=> !idle)
    else $error("inverter port idle, scanning stopped");
  a_no_poll: assert property (inv_req_valid_o |-> fwd_q || scan_f(inv_req_o.regnum))
    else $error("non-scanned register accessed without a request");
endmodule : rmg_gateway_sva

bind rmg_gateway rmg_gateway_sva #(.MIR_DEPTH(MIR_DEPTH)) u_rmg_gateway_sva (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .net_req_valid_i(net_req_valid_i), .net_req_ready_o(net_req_ready_o),
  .net_req_i(net_req_i), .net_rsp_valid_o(net_rsp_valid_o),
  .net_rsp_ready_i(net_rsp_ready_i), .net_rsp_o(net_rsp_o),
  .inv_req_valid_o(inv_req_valid_o), .inv_req_ready_i(inv_req_ready_i),
  .inv_req_o(inv_req_o), .inv_rsp_valid_i(inv_rsp_valid_i)
);

// >>> sim/rmg_inv_model.sv
// behavioural inverter drive holding the function-code registers
`timescale 1ns/100ps
`include "rmg_cfg.svh"

module rmg_inv_model
  import rmg_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // access from the gateway
  input  wire logic         req_valid_i,
  output logic              req_ready_o,
  input  wire rmg_inv_req_s req_i,
  // answer to the gateway
  output logic              rsp_valid_o,
  output rmg_inv_rsp_s      rsp_o
);
  // ------------------------------------------------------------------
  // register store, unwritten codes read a fixed pattern
  // ------------------------------------------------------------------
  logic [15:0]  mem [logic [15:0]];
  rmg_inv_req_s cur_q;
  int unsigned  wait_q;
  logic         busy_q;
  logic [7:0]   off;

  // one access at a time, random stall before ready and before the answer
  always @(posedge clk_i) begin
    rsp_valid_o <= 1'b0;
    rsp_o       <= ~rsp_o;  // meaningless between answers
    off         = cur_q.regnum[7:0] - 8'h01;
    if (rst_i) begin
      req_ready_o <= 1'b0;
      busy_q      <= 1'b0;
      rsp_o       <= '0;
    end else if (!busy_q) begin
      req_ready_o <= req_valid_i && !req_ready_o && $urandom_range(0, 2) == 0;
      if (req_valid_i && req_ready_o) begin
        cur_q  <= req_i;
        busy_q <= 1'b1;
        wait_q <= $urandom_range(0, 5);
      end
    end else if (wait_q != 0) begin
      wait_q <= wait_q - 1;
    end else begin
      busy_q      <= 1'b0;
      rsp_valid_o <= 1'b1;
      if (off >= 8'h60 && off <= 8'h6f)
        rsp_o <= {~cur_q.regnum, 2'b11};  // no such code
      else if (cur_q.write && cur_q.wdata == 16'hffff)
        rsp_o <= {16'h0000, 2'b10};  // value refused
      else if (cur_q.write) begin
        mem[cur_q.regnum] = cur_q.wdata;
        rsp_o <= '0;
      end else
        rsp_o <= {mem.exists(cur_q.regnum) ? mem[cur_q.regnum] : cur_q.regnum ^ 16'h5a5a, 2'b00};
    end
  end
endmodule : rmg_inv_model

// >>> sim/rmg_gateway_tb.sv
// self-checking bench of the register mirror gateway
`timescale 1ns/100ps
`include "rmg_cfg.svh"

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module rmg_gateway_tb
  import rmg_pkg::*;
;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         ce_i = 1'b1;  // held high, freezing is not exercised
  logic         net_req_valid_i = 1'b0;
  logic         net_req_ready_o;
  rmg_net_req_s net_req_i = '0;
  logic         net_wd_valid_i = 1'b0;
  logic         net_wd_ready_o;
  logic [15:0]  net_wd_i = '0;
  logic         net_rsp_valid_o;
  logic         net_rsp_ready_i = 1'b0;
  rmg_net_rsp_s net_rsp_o, mon_e;
  logic         inv_req_valid_o, inv_req_ready_i, inv_rsp_valid_i;
  rmg_inv_req_s inv_req_o;
  rmg_inv_rsp_s inv_rsp_i;
  int           fails = 0;
  int           compares = 0;
  logic         done = 1'b0;
  rmg_net_rsp_s exp_q [$];
  logic [15:0]  sh [logic [15:0]];
  logic [7:0]   grp [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0d, 8'h0e, 8'h10, 8'h11};
  logic [15:0]  r;

  // ------------------------------------------------------------------
  // design and inverter
  // ------------------------------------------------------------------
  rmg_gateway #(.MIR_DEPTH(`RMG_MIR_DEPTH)) u_rmg_gateway (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .net_req_valid_i(net_req_valid_i), .net_req_ready_o(net_req_ready_o),
    .net_req_i(net_req_i), .net_wd_valid_i(net_wd_valid_i),
    .net_wd_ready_o(net_wd_ready_o), .net_wd_i(net_wd_i),
    .net_rsp_valid_o(net_rsp_valid_o), .net_rsp_ready_i(net_rsp_ready_i),
    .net_rsp_o(net_rsp_o), .inv_req_valid_o(inv_req_valid_o),
    .inv_req_ready_i(inv_req_ready_i), .inv_req_o(inv_req_o),
    .inv_rsp_valid_i(inv_rsp_valid_i), .inv_rsp_i(inv_rsp_i));
  rmg_inv_model u_rmg_inv_model (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(inv_req_valid_o),
    .req_ready_o(inv_req_ready_i), .req_i(inv_req_o),
    .rsp_valid_o(inv_rsp_valid_i), .rsp_o(inv_rsp_i));

  // free-running clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic scan_f(input logic [15:0] a);
    return (a >= `RMG_S_FIRST && a <= `RMG_S_LAST) || (a >= `RMG_M1_FIRST && a <= `RMG_M1_LAST)
      || (a >= `RMG_M2_FIRST && a <= `RMG_M2_LAST);
  endfunction : scan_f
  // offsets the inverter model lacks
  function automatic logic gone_f(input logic [15:0] a);
    return a[7:0] - 8'h01 >= 8'h60 && a[7:0] - 8'h01 <= 8'h6f;
  endfunction : gone_f
  function automatic logic [15:0] reg_f(input logic [7:0] g, input logic [7:0] o);
    return {g, o} + 16'h0001;
  endfunction : reg_f

  // note the expected beats, then drive the request and its write words
  task automatic txn(input logic wr, input logic [15:0] st, input logic [7:0] cnt,
                     input logic [15:0] d0);
    logic [15:0] w [$];
    logic [15:0] a, e;
    logic        stop, lst;
    int          n;
    stop = 1'b0;
    done = 1'b0;
    for (int i = 0; i < int'(cnt); i++) w.push_back(i == 0 ? d0 : 16'($urandom_range(0, 65534)));
    if (cnt == 8'h00 || (!scan_f(st) && cnt > `RMG_MAX_NS)) begin
      exp_q.push_back({16'h0000, 2'b11});
      stop = 1'b1;
    end
    for (int i = 0; i < int'(cnt) && !stop; i++) begin
      a   = st + 16'(i);
      lst = i == int'(cnt) - 1;
      e   = 16'h0000;
      if (scan_f(st)) begin
        if (wr && a <= `RMG_S_LAST) sh[a] = w[i];
        else if (a <= `RMG_S_LAST) e = sh.exists(a) ? sh[a] : 16'h0000;
        else if (!wr) e = gone_f(a) ? 16'h0000 : a ^ 16'h5a5a;
      end else if (i > 0 && (gone_f(a) || (a - 16'h1) >> 8 != (st - 16'h1) >> 8))
        e = 16'h0000;
      else if (gone_f(a) || (wr && w[i] == 16'hffff)) stop = 1'b1;
      else if (wr) sh[a] = w[i];
      else e = sh.exists(a) ? sh[a] : a ^ 16'h5a5a;
      exp_q.push_back(stop ? {16'h0000, 2'b11} : {e, 1'b0, lst});
    end
    @(posedge clk_i);
    net_req_valid_i <= 1'b1;
    net_req_i       <= '{wr, st, cnt};
    do @(posedge clk_i); while (!net_req_ready_o);
    net_req_valid_i <= 1'b0;
    for (int i = 0; wr && i < int'(cnt) && !done; i++) begin
      net_wd_valid_i <= 1'b1;
      net_wd_i       <= w[i];
      do @(posedge clk_i); while (!net_wd_ready_o && !done);
    end
    net_wd_valid_i <= 1'b0;
    while (!done) @(posedge clk_i);
  endtask : txn

  // take the oldest note for every accepted beat, stall at random
  always @(posedge clk_i) begin
    if (net_rsp_valid_o === 1'b1 && net_rsp_ready_i) begin
      mon_e = exp_q.size() > 0 ? exp_q.pop_front() : 18'h3ffff;
      if (mon_e.err) `CHK("error beat", mon_e[1:0], net_rsp_o[1:0])
      else `CHK("response beat", mon_e, net_rsp_o)
      if (mon_e.last) done = 1'b1;
    end
    net_rsp_ready_i <= $urandom_range(0, 3) != 0;
  end

  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // cut a hang short
  initial begin
    #240000;
    fails++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    void'($urandom(32'h8c7c));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    txn(1'b1, `RMG_S_FIRST, 8'd3, 16'hffff);
    txn(1'b0, `RMG_S_FIRST, 8'd14, 16'h0000);
    repeat (3000) @(posedge clk_i);
    txn(1'b0, `RMG_M1_FIRST, 8'd73, 16'h0000);
    txn(1'b0, `RMG_M2_FIRST, 8'd96, 16'h0000);
    foreach (grp[k]) begin
      r = reg_f(grp[k], 8'($urandom_range(0, 95)));
      txn(1'b1, r, 8'd1, 16'($urandom_range(0, 65534)));
      txn(1'b0, r, 8'd1, 16'h0000);
    end
    txn(1'b1, reg_f(8'h00, 8'h07), 8'd1, 16'hffff);
    txn(1'b0, reg_f(8'h01, 8'h60), 8'd1, 16'h0000);
    txn(1'b1, reg_f(8'h01, 8'h65), 8'd1, 16'h1234);
    txn(1'b1, reg_f(8'h00, 8'h5e), 8'd3, 16'h4321);
    txn(1'b0, reg_f(8'h00, 8'h5e), 8'd3, 16'h0000);
    txn(1'b0, reg_f(8'h00, 8'h61), 8'd2, 16'h0000);
    txn(1'b1, reg_f(8'h00, 8'h61), 8'd2, 16'h0042);
    txn(1'b1, reg_f(8'h00, 8'hfe), 8'd4, 16'h0bad);
    txn(1'b0, reg_f(8'h00, 8'hfe), 8'd4, 16'h0000);
    txn(1'b0, reg_f(8'h01, 8'h00), 8'd2, 16'h0000);
    txn(1'b0, reg_f(8'h02, 8'h00), 8'd50, 16'h0000);
    txn(1'b0, reg_f(8'h02, 8'h00), 8'd51, 16'h0000);
    txn(1'b1, reg_f(8'h02, 8'h00), 8'd51, 16'h0000);
    txn(1'b0, reg_f(8'h02, 8'h00), 8'd0, 16'h0000);
    `CHK("notes left", 0, exp_q.size())
    tally_and_finish();
  end
endmodule : rmg_gateway_tb
